/* include/adc_regs_pkg.sv */
// register map, field positions and pattern codes of the adc control bank
// assumes a serial-port front end that delivers decoded byte writes and reads
// How it works
// - writing bit 0 of the transfer register copies every staged value into its active copy.
// - staged writes to 0x08..0x18 change nothing until 0x01 lands in 0xff; the bit then clears itself.
// - with the mode pin enabled by bit 7 of the modes register, a high pin applies the action in bits 6:5.
// - the pin action code 00 means full power-down and 01 means standby.
// - the sampling clock divides by the 3-bit field plus one.
// - any selected test mode puts test data on the parallel outputs instead of samples.
// - test codes 0000..0100 are off, midscale, positive full scale, negative full scale, checkerboard.
// - test codes 0101 and 0110 select the long pseudorandom sequence, and the short one in the top 9 bits over low bits of the long one.
// - test codes 0111..1100 are word toggle, user pattern, bit toggle, sync, one bit high, mixed.
// - the checkerboard code puts alternating checkerboard words on the outputs.
package adc_regs_pkg;
	localparam logic [7:0] addr_operating_modes = 8'h08;
	localparam logic [7:0] addr_clock_divide_ratio = 8'h0b;
	localparam logic [7:0] addr_output_test_pattern = 8'h0d;
	localparam logic [7:0] addr_self_test_control = 8'h0e;
	localparam logic [7:0] addr_offset_trim = 8'h10;
	localparam logic [7:0] addr_shadow_update = 8'hff;
	localparam logic [7:0] shadow_first = 8'h08;
	localparam logic [7:0] shadow_last = 8'h18;
	localparam logic [7:0] reset_value = 8'h00;
	localparam int pin_enable_bit = 7;
	localparam int transfer_bit = 0;
	localparam int pn_long_reset_bit = 5;
	localparam int pn_short_reset_bit = 4;
	localparam int self_test_start_bit = 0;
	localparam int self_test_initialise_bit = 2;
	localparam logic [22:0] pn23_seed = 23'h7fffff;
	localparam logic [8:0] pn9_seed = 9'h1ff;
	localparam logic [15:0] self_test_seed = 16'hffff;
	localparam logic [7:0] self_test_cycles = 8'hff;
	typedef enum logic [1:0] {
		pin_power_down = 2'b00, pin_standby = 2'b01, pin_rsv2 = 2'b10, pin_rsv3 = 2'b11
	} pin_action_t;
	typedef enum logic [1:0] {
		run_chip = 2'b00, run_power_down = 2'b01, run_standby = 2'b10, run_digital_reset = 2'b11
	} chip_mode_t;
	typedef enum logic [3:0] {
		tp_off = 4'h0, tp_midscale = 4'h1, tp_pos_fs = 4'h2, tp_neg_fs = 4'h3,
		tp_checker = 4'h4, tp_pn23 = 4'h5, tp_pn9 = 4'h6, tp_word_toggle = 4'h7,
		tp_user = 4'h8, tp_bit_toggle = 4'h9, tp_sync = 4'ha, tp_one_bit_high = 4'hb,
		tp_mixed = 4'hc
	} test_pattern_t;
	typedef enum logic [1:0] {
		st_idle = 2'b00, st_init = 2'b01, st_run = 2'b10, st_done = 2'b11
	} self_test_state_t;
endpackage

/* design/adc_control_register_bank.sv */
// adc control register bank: staged program registers, active copies, test pattern output
// assumes the serial port gives one-cycle write/read strobes with a byte address, synchronous to clk
`timescale 1ns/1ps
module adc_control_register_bank #(
	parameter int data_width = 14
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata,
	output logic rd_valid,
	input wire logic mode_pin,
	input wire logic [data_width-1:0] sample_data,
	input wire logic [data_width-1:0] user_pattern,
	output logic [data_width-1:0] data_out,
	output logic power_down,
	output logic standby,
	output logic digital_reset,
	output logic [2:0] clock_divide,
	output logic [7:0] offset_value,
	output logic self_test_busy,
	output logic self_test_done,
	output logic [15:0] self_test_signature
);
	import adc_regs_pkg::*;

	logic [7:0] stage_modes, stage_div, stage_test, stage_bist, stage_offset;
	logic [7:0] act_modes, act_div, act_test, act_bist, act_offset;
	logic transfer_flag;
	logic next_transfer;
	logic [22:0] pn23;
	logic [8:0] pn9;
	logic toggle;
	logic [3:0] walk;
	logic [15:0] sig;
	logic [7:0] st_count;
	self_test_state_t st_state;
	logic bist_armed;
	logic pin_pd, pin_sb;
	chip_mode_t chip_mode;
	pin_action_t pin_action;
	logic [data_width-1:0] next_data;

	assign next_transfer = wr_en && addr == addr_shadow_update && wdata[transfer_bit];

	// each program byte: staged copy for the host, active copy for the chip
	shadow_byte #(.map_addr(addr_operating_modes), .keep_mask(8'he3)) modes_pair (
		.clk(clk),
		.nrst(nrst),
		.wr_en(wr_en),
		.addr(addr),
		.wdata(wdata),
		.load(transfer_flag),
		.staged(stage_modes),
		.active(act_modes)
	);

	shadow_byte #(.map_addr(addr_clock_divide_ratio), .keep_mask(8'h07)) divide_pair (
		.clk(clk),
		.nrst(nrst),
		.wr_en(wr_en),
		.addr(addr),
		.wdata(wdata),
		.load(transfer_flag),
		.staged(stage_div),
		.active(act_div)
	);

	shadow_byte #(.map_addr(addr_output_test_pattern), .keep_mask(8'hff)) pattern_pair (
		.clk(clk),
		.nrst(nrst),
		.wr_en(wr_en),
		.addr(addr),
		.wdata(wdata),
		.load(transfer_flag),
		.staged(stage_test),
		.active(act_test)
	);

	shadow_byte #(.map_addr(addr_self_test_control), .keep_mask(8'h05)) self_test_pair (
		.clk(clk),
		.nrst(nrst),
		.wr_en(wr_en),
		.addr(addr),
		.wdata(wdata),
		.load(transfer_flag),
		.staged(stage_bist),
		.active(act_bist)
	);

	shadow_byte #(.map_addr(addr_offset_trim), .keep_mask(8'hff)) trim_pair (
		.clk(clk),
		.nrst(nrst),
		.wr_en(wr_en),
		.addr(addr),
		.wdata(wdata),
		.load(transfer_flag),
		.staged(stage_offset),
		.active(act_offset)
	);

	// transfer bit set for one cycle, then autoclears
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			transfer_flag <= 1'b0;
		end else begin
			transfer_flag <= next_transfer;
		end
	end

	// reads return the staged view; transfer shows its pending bit
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata <= 8'h00;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= rd_en;
			if (rd_en) begin
				case (addr)
					addr_operating_modes: rdata <= stage_modes;
					addr_clock_divide_ratio: rdata <= stage_div;
					addr_output_test_pattern: rdata <= stage_test;
					addr_self_test_control: rdata <= stage_bist;
					addr_offset_trim: rdata <= stage_offset;
					addr_shadow_update: rdata <= {7'h00, transfer_flag};
					default: rdata <= 8'h00;
				endcase
			end
		end
	end

	assign chip_mode = chip_mode_t'(act_modes[1:0]);
	assign pin_action = pin_action_t'(act_modes[6:5]);
	assign pin_pd = act_modes[pin_enable_bit] && mode_pin && pin_action == pin_power_down;
	assign pin_sb = act_modes[pin_enable_bit] && mode_pin && pin_action == pin_standby;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			power_down <= 1'b0;
			standby <= 1'b0;
			digital_reset <= 1'b0;
			clock_divide <= 3'h0;
			offset_value <= 8'h00;
		end else begin
			// pin power-down overrides a register standby
			power_down <= pin_pd || chip_mode == run_power_down;
			standby <= !pin_pd && (pin_sb || chip_mode == run_standby);
			digital_reset <= chip_mode == run_digital_reset;
			// divide ratio is field plus one; output carries the raw field
			clock_divide <= act_div[2:0];
			offset_value <= act_offset;
		end
	end

	// each generator sits on its seed while its reset bit is held
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pn23 <= pn23_seed;
		end else if (act_test[pn_long_reset_bit]) begin
			pn23 <= pn23_seed;
		end else begin
			pn23 <= {pn23[21:0], pn23[22] ^ pn23[17]};
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pn9 <= pn9_seed;
		end else if (act_test[pn_short_reset_bit]) begin
			pn9 <= pn9_seed;
		end else begin
			pn9 <= {pn9[7:0], pn9[8] ^ pn9[4]};
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			toggle <= 1'b0;
		end else begin
			toggle <= !toggle;
		end
	end

	// walking index for the one-bit-high pattern, wraps at the top data bit
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			walk <= 4'h0;
		end else begin
			walk <= (walk == 4'(data_width - 1)) ? 4'h0 : walk + 4'h1;
		end
	end

	// pattern select; unknown codes fall back to live samples
	always_comb begin
		next_data = sample_data;
		case (test_pattern_t'(act_test[3:0]))
			tp_off: next_data = sample_data;
			tp_midscale: next_data = {1'b1, {(data_width-1){1'b0}}};
			tp_pos_fs: next_data = {data_width{1'b1}};
			tp_neg_fs: next_data = {data_width{1'b0}};
			tp_checker: next_data = toggle ? {(data_width/2){2'b01}} : {(data_width/2){2'b10}};
			tp_pn23: next_data = pn23[22 -: data_width];
			tp_pn9: next_data = {pn9, pn23[data_width-10:0]};
			tp_word_toggle: next_data = {data_width{toggle}};
			tp_user: next_data = user_pattern;
			tp_bit_toggle: next_data = toggle ? {(data_width/2){2'b10}} : {(data_width/2){2'b01}};
			tp_sync: next_data = {{(data_width-7){1'b0}}, 7'h7f};
			tp_one_bit_high: next_data = data_width'(1) << walk;
			tp_mixed: next_data = {toggle, pn9[0], {(data_width-2){toggle}}};
			default: next_data = sample_data;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			data_out <= '0;
		end else begin
			data_out <= next_data;
		end
	end

	// self-test: a start bit arms one run; clearing it rearms
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_state <= st_idle;
			st_count <= 8'h00;
			sig <= self_test_seed;
			bist_armed <= 1'b1;
			self_test_busy <= 1'b0;
			self_test_done <= 1'b0;
			self_test_signature <= 16'h0000;
		end else begin
			case (st_state)
				st_idle: begin
					if (!act_bist[self_test_start_bit]) begin
						bist_armed <= 1'b1;
					end else if (bist_armed) begin
						bist_armed <= 1'b0;
						self_test_busy <= 1'b1;
						self_test_done <= 1'b0;
						st_count <= 8'h00;
						st_state <= act_bist[self_test_initialise_bit] ? st_init : st_run;
					end
				end
				st_init: begin
					sig <= self_test_seed;
					st_state <= st_run;
				end
				st_run: begin
					sig <= {sig[14:0], sig[15] ^ sig[13] ^ sig[12] ^ sig[10]} ^
						{{(16-data_width){1'b0}}, next_data};
					st_count <= st_count + 8'h01;
					if (st_count == self_test_cycles) begin
						st_state <= st_done;
					end
				end
				st_done: begin
					self_test_busy <= 1'b0;
					self_test_done <= 1'b1;
					self_test_signature <= sig;
					st_state <= st_idle;
				end
				default: st_state <= st_idle;
			endcase
		end
	end
endmodule

// one host byte: a staged copy written at once, an active copy moved on transfer
module shadow_byte #(
	parameter logic [7:0] map_addr = 8'h00,
	parameter logic [7:0] keep_mask = 8'hff
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic wr_en,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic load,
	output logic [7:0] staged,
	output logic [7:0] active
);
	import adc_regs_pkg::*;

	// open bits never reach the staged copy, so reads show them as zero
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			staged <= reset_value;
		end else if (wr_en && addr == map_addr) begin
			staged <= wdata & keep_mask;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			active <= reset_value;
		end else if (load) begin
			active <= staged;
		end
	end
endmodule

/* test/adc_bank_monitor.sv */
// assertion checker for the adc control bank, sees the top-level ports only
// assumes async active-low nrst and one-cycle host strobes
`timescale 1ns/1ps
module adc_bank_monitor (
	input wire logic clk,
	input wire logic nrst,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic rd_valid,
	input wire logic mode_pin,
	input wire logic power_down,
	input wire logic [2:0] clock_divide,
	input wire logic [7:0] offset_value,
	input wire logic self_test_busy,
	input wire logic self_test_done
);
	logic xfer;
	logic [3:0] hist;
	logic [2:0] sdiv;
	// a transfer may take a few edges to land, so keep a short history
	assign xfer = wr_en && addr == 8'hff && wdata[0];
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hist <= 4'h0;
			sdiv <= 3'h0;
		end else begin
			hist <= {hist[2:0], xfer};
			if (wr_en && addr == 8'h0b) sdiv <= wdata[2:0];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_read_answer: assert property (rd_en |=> rd_valid) else $error("read not answered");
	a_valid_pulse: assert property (!rd_en |=> !rd_valid) else $error("stray read valid");
	a_div_staged: assert property (!$stable(clock_divide) |-> hist != 4'h0)
		else $error("divider moved without transfer");
	a_trim_staged: assert property (!$stable(offset_value) |-> hist != 4'h0)
		else $error("offset moved without transfer");
	a_xfer_apply: assert property (xfer |-> ##[1:4] clock_divide == sdiv)
		else $error("transfer not applied");
	a_pd_cause: assert property ($rose(power_down) |-> hist != 4'h0 || $past(mode_pin))
		else $error("power down without cause");
	a_unmapped_zero: assert property (rd_en && addr == 8'h20 |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	a_bist_excl: assert property (self_test_done |-> !self_test_busy)
		else $error("self-test busy and done");
	c_xfer: cover property (xfer);
	c_pin: cover property ($rose(power_down));
	c_bist: cover property ($rose(self_test_done));
endmodule
bind adc_control_register_bank adc_bank_monitor mon (.clk, .nrst, .wr_en, .rd_en, .addr,
	.wdata, .rdata, .rd_valid, .mode_pin, .power_down, .clock_divide, .offset_value,
	.self_test_busy, .self_test_done);

/* test/spi_host_model.sv */
// host model of the serial port front end: single byte writes and reads
// assumes strobes taken on the rising edge, read answered one cycle later
`timescale 1ns/1ps
module spi_host_model (
	input wire logic clk,
	input wire logic [7:0] rdata,
	input wire logic rd_valid,
	output logic wr_en,
	output logic rd_en,
	output logic [7:0] addr,
	output logic [7:0] wdata
);
	initial begin
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
	end
	// idle bus shows the inverse, never a stale address
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk);
		wr_en = 1'b1;
		addr = a;
		wdata = v;
		@(negedge clk);
		wr_en = 1'b0;
		addr = ~a;
		wdata = ~v;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic ok);
		@(negedge clk);
		rd_en = 1'b1;
		addr = a;
		@(negedge clk);
		rd_en = 1'b0;
		addr = ~a;
		ok = rd_valid;
		v = rdata;
	endtask
endmodule

/* test/adc_control_register_bank_tb.sv */
// self-checking bench for the adc control bank driven through the host model
// assumes a 250 MHz clk; inputs change on the falling edge
`timescale 1ns/1ps
module adc_control_register_bank_tb;
	import adc_regs_pkg::*;
	logic clk, nrst, mode_pin, wr_en, rd_en, rd_valid, ok;
	logic power_down, standby, digital_reset, self_test_busy, self_test_done;
	logic [7:0] addr, wdata, rdata, offset_value, v;
	logic [2:0] clock_divide;
	logic [13:0] sample_data, user_pattern, data_out, p;
	logic [15:0] self_test_signature;
	int error_cnt = 0;
	int checks = 0;
	spi_host_model host (.clk, .rdata, .rd_valid, .wr_en, .rd_en, .addr, .wdata);
	adc_control_register_bank #(.data_width(14)) uut (.clk, .nrst, .wr_en, .rd_en, .addr,
		.wdata, .rdata, .rd_valid, .mode_pin, .sample_data, .user_pattern, .data_out,
		.power_down, .standby, .digital_reset, .clock_divide, .offset_value,
		.self_test_busy, .self_test_done, .self_test_signature);
	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic set(input logic [7:0] a, input logic [7:0] x);
		host.wr(a, x);
		host.wr(addr_shadow_update, 8'h01);
		repeat (4) @(negedge clk);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		host.rd(a, v, ok);
		chk("rd_valid", 16'h1, {15'h0, ok});
		chk("rdata", {8'h0, e}, {8'h0, v});
	endtask
	task automatic t_reset;
		logic [7:0] regs [7] = '{8'h08, 8'h0b, 8'h0d, 8'h0e, 8'h10, 8'hff, 8'h20};
		foreach (regs[i]) rd_chk(regs[i], 8'h00);
	endtask
	task automatic t_staged;
		host.wr(addr_clock_divide_ratio, 8'hfb);
		host.wr(addr_offset_trim, 8'h5a);
		repeat (4) @(negedge clk);
		chk("clock_divide", 16'h0, {13'h0, clock_divide});
		set(addr_offset_trim, 8'h5a);
		chk("clock_divide", 16'h3, {13'h0, clock_divide});
		chk("offset_value", 16'h5a, {8'h0, offset_value});
		rd_chk(addr_shadow_update, 8'h00);
		rd_chk(addr_clock_divide_ratio, 8'h03);
		rd_chk(addr_offset_trim, 8'h5a);
	endtask
	task automatic alt_chk(input logic [3:0] code, input logic [13:0] a);
		set(addr_output_test_pattern, {4'h0, code});
		p = data_out;
		@(negedge clk);
		chk("pattern word", 16'h1, {15'h0, p === a || p === ~a});
		chk("pattern alt", {2'b0, ~p}, {2'b0, data_out});
	endtask
	task automatic t_pattern;
		logic [3:0] code [6] = '{4'h1, 4'h2, 4'h3, 4'h8, 4'ha, 4'h0};
		logic [13:0] e [6] = '{14'h2000, 14'h3fff, 14'h0000, 14'h0abc, 14'h007f, 14'h1234};
		alt_chk(4'h4, 14'h1555);
		alt_chk(4'h7, 14'h0000);
		alt_chk(4'h9, 14'h1555);
		foreach (code[i]) begin
			set(addr_output_test_pattern, {4'h0, code[i]});
			chk("data_out", {2'b0, e[i]}, {2'b0, data_out});
		end
		set(addr_output_test_pattern, 8'h25);
		p = data_out;
		@(negedge clk);
		chk("pn held", {2'b0, p}, {2'b0, data_out});
		chk("pn long seed", {2'b0, pn23_seed[22:9]}, {2'b0, data_out});
		set(addr_output_test_pattern, 8'h05);
		p = data_out;
		// zeros enter at the bottom, so the top word needs ten shifts from the seed to move
		repeat (12) @(negedge clk);
		chk("pn runs", 16'h1, {15'h0, data_out !== p});
		set(addr_output_test_pattern, 8'h36);
		chk("pn short seed", {2'b0, pn9_seed, pn23_seed[4:0]}, {2'b0, data_out});
		set(addr_output_test_pattern, 8'h06);
		p = data_out;
		repeat (12) @(negedge clk);
		chk("pn short runs", 16'h1, {15'h0, data_out !== p});
		set(addr_output_test_pattern, 8'h0b);
		chk("one bit high", 16'h1, {15'h0, $onehot(data_out)});
		set(addr_output_test_pattern, 8'h00);
	endtask
	task automatic t_pin;
		mode_pin = 1'b1;
		set(addr_operating_modes, 8'h20);
		chk("pin disabled", 16'h0, {15'h0, standby | power_down});
		set(addr_operating_modes, 8'h80);
		chk("power_down", 16'h1, {15'h0, power_down});
		set(addr_operating_modes, 8'ha0);
		chk("standby", 16'h1, {15'h0, standby & ~power_down});
		mode_pin = 1'b0;
		repeat (2) @(negedge clk);
		chk("standby off", 16'h0, {15'h0, standby});
		set(addr_operating_modes, 8'h01);
		chk("mode power_down", 16'h1, {15'h0, power_down});
		set(addr_operating_modes, 8'h02);
		chk("mode standby", 16'h1, {15'h0, standby});
		set(addr_operating_modes, 8'h03);
		chk("digital_reset", 16'h1, {15'h0, digital_reset});
		set(addr_operating_modes, 8'h00);
		chk("digital_reset", 16'h0, {15'h0, digital_reset});
	endtask
	task automatic wait_done;
		for (int n = 0; n < 600 && self_test_done !== 1'b1; n++) @(negedge clk);
		chk("self_test_done", 16'h1, {15'h0, self_test_done});
		if (self_test_done !== 1'b1) close_out();
	endtask
	task automatic t_bist;
		logic [15:0] first_sig;
		set(addr_self_test_control, 8'h05);
		chk("self_test_busy", 16'h1, {15'h0, self_test_busy});
		wait_done();
		chk("self_test_busy", 16'h0, {15'h0, self_test_busy});
		first_sig = self_test_signature;
		// clearing the start bit rearms; init must make a rerun repeat the signature
		set(addr_self_test_control, 8'h00);
		set(addr_self_test_control, 8'h05);
		wait_done();
		chk("self_test_signature", first_sig, self_test_signature);
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		nrst = 1'b0;
		mode_pin = 1'b0;
		sample_data = 14'h1234;
		user_pattern = 14'h0abc;
		repeat (4) @(negedge clk);
		nrst = 1'b1;
		t_reset();
		t_staged();
		t_pattern();
		t_pin();
		t_bist();
		close_out();
	end
endmodule
